// File: shared/osc_defines.vh
// constants for the oversampling conversion control block
// assumes inclusion by bare name from hdl files
`ifndef OSC_DEFINES_VH
`define OSC_DEFINES_VH
`define OSC_CHANNELS      4
`define OSC_DATA_W        16
`define OSC_ACC_W         23
`define OSC_RATIO_W       3
`define OSC_RATIO_RESET   3'h0
`define OSC_RATIO_MAX     3'h6
// cycles per single converter sample while busy
`define OSC_SAMPLE_CYCLES 8'h0C
`endif

// File: hdl/osc_conversion_control.v
// oversampling control and conversion timing for four channels
// every output is registered, with no combinational path to a pin
// assumes a converter core presenting one sample set per strobe on clk_sys,
// and pin inputs arriving asynchronously from the board
`timescale 1ns/1ps
`include "osc_defines.vh"

// Operation
// - ratio pins captured when busy falls
// - busy length grows with averaging ratio
// - reads during busy return previous results
// - output registers load when busy falls
// - averaging filter applied when ratio selected
// - reads allowed during conversion, any mode
module osc_conversion_control (
  // clock and reset
  input  wire                          clk_sys,
  input  wire                          rst,
  // pins from host
  input  wire [2:0]                    averaging_ratio_select,
  input  wire                          convert_start_first_half,
  input  wire                          convert_start_second_half,
  // converter core
  output reg                           sampleRequest,
  input  wire                          sampleValid,
  input  wire [4*`OSC_DATA_W-1:0]      sampleData,
  // status and results
  output reg                           busy,
  output reg  [2:0]                    averaging_ratio,
  output reg  [4*`OSC_DATA_W-1:0]      resultData
);

  // one-hot: a corrupted code falls into the default branch and idles
  localparam ST_IDLE = 3'b001;
  localparam ST_SAMP = 3'b010;
  localparam ST_WAIT = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // three-stage pin synchronisers
  // start pair and ratio pins share one depth, so a code moved together
  // with the start is seen no later than the start itself
  reg [2:0] selS1, selS2, selS3;
  reg [1:0] cvS1, cvS2, cvS3;
  reg       startSeen;

  always @(posedge clk_sys) begin
    if (rst) begin
      selS1 <= 3'h0;
      selS2 <= 3'h0;
      selS3 <= 3'h0;
      cvS1  <= 2'h0;
      cvS2  <= 2'h0;
      cvS3  <= 2'h0;
    end else begin
      selS1 <= averaging_ratio_select;
      selS2 <= selS1;
      selS3 <= selS2;
      cvS1  <= {convert_start_second_half, convert_start_first_half};
      cvS2  <= cvS1;
      cvS3  <= cvS2;
    end
  end

  // both halves rise together when oversampling; a start counts only once
  // both halves are seen high, so a skewed pair still gives one conversion
  wire bothHigh  = (cvS2 == 2'h3) && (cvS3 == 2'h3);
  wire selStable = (selS2 == selS3);

  ////////////////////////////////////////////////////////////////////////////
  // sample count for a ratio code: 2^code, code 7 treated as none
  function [7:0] samplesFor;
    input [2:0] code;
    begin
      if (code > `OSC_RATIO_MAX)
        samplesFor = 8'h01;
      else
        samplesFor = 8'h01 << code;
    end
  endfunction

  // divide shift for the mean, kept in step with samplesFor
  function [2:0] shiftFor;
    input [2:0] code;
    begin
      if (code > `OSC_RATIO_MAX)
        shiftFor = 3'h0;
      else
        shiftFor = code;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  reg [2:0]              state;
  reg [7:0]              samplesLeft;
  reg [7:0]              gapCount;
  reg                    armed;
  reg [4*`OSC_ACC_W-1:0] acc;
  wire                   lastSample = sampleValid && (samplesLeft == 8'h01);
  wire                   lastDone   = (state == ST_SAMP) && lastSample;
  // a start needs a fresh rise of both halves while idle; pins held high
  // through a whole conversion never start a second one
  wire                   startFire  = (state == ST_IDLE) && bothHigh
                                      && !startSeen && armed;

  ////////////////////////////////////////////////////////////////////////////
  // start detection
  always @(posedge clk_sys) begin
    if (rst) begin
      startSeen <= 1'b0;
      armed     <= 1'b1;
    end else begin
      startSeen <= bothHigh;
      if (startFire)
        armed <= 1'b0;
      else if ((state == ST_IDLE) && !bothHigh)
        armed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy and sample timing
  always @(posedge clk_sys) begin
    if (rst) begin
      state           <= ST_IDLE;
      busy            <= 1'b0;
      sampleRequest   <= 1'b0;
      samplesLeft     <= 8'h00;
      gapCount        <= 8'h00;
    end else begin
      sampleRequest <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (startFire) begin
            busy        <= 1'b1;
            // longer busy for higher ratio: one sample slot per average
            samplesLeft <= samplesFor(averaging_ratio);
            gapCount    <= `OSC_SAMPLE_CYCLES;
            state       <= ST_WAIT;
          end
        end

        ST_WAIT: begin
          if (gapCount == 8'h01) begin
            sampleRequest <= 1'b1;
            state         <= ST_SAMP;
          end else begin
            gapCount <= gapCount - 8'h01;
          end
        end

        ST_SAMP: begin
          if (sampleValid) begin
            samplesLeft <= samplesLeft - 8'h01;
            if (lastSample) begin
              busy  <= 1'b0;
              state <= ST_IDLE;
            end else begin
              gapCount <= `OSC_SAMPLE_CYCLES;
              state    <= ST_WAIT;
            end
          end
        end

        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ratio capture as busy drops; the new ratio serves the next conversion
  // pins are taken only when two synchroniser stages agree, so a code
  // still settling at that edge leaves the old ratio in force
  always @(posedge clk_sys) begin
    if (rst)
      averaging_ratio <= `OSC_RATIO_RESET;
    else if (lastDone && selStable)
      averaging_ratio <= selS3;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel averaging filter and output registers
  genvar ch;
  generate
    for (ch = 0; ch < `OSC_CHANNELS; ch = ch + 1) begin : gChan
      wire [`OSC_ACC_W-1:0]  accCh = acc[ch*`OSC_ACC_W +: `OSC_ACC_W];
      wire [`OSC_DATA_W-1:0] smp   = sampleData[ch*`OSC_DATA_W +: `OSC_DATA_W];
      // samples are two's complement; sign extend into the accumulator
      wire [`OSC_ACC_W-1:0]  smpX  = {{(`OSC_ACC_W-`OSC_DATA_W){smp[15]}},
                                      smp};
      wire [`OSC_ACC_W-1:0]  sum   = accCh + smpX;
      // arithmetic shift divides by the exact power-of-two count
      wire [`OSC_ACC_W-1:0]  mean  =
        $signed(sum) >>> shiftFor(averaging_ratio);

      // clearing on the last sample lets the next conversion start at zero
      always @(posedge clk_sys) begin
        if (rst) begin
          acc[ch*`OSC_ACC_W +: `OSC_ACC_W]         <= {`OSC_ACC_W{1'b0}};
          resultData[ch*`OSC_DATA_W +: `OSC_DATA_W] <= 16'h0000;
        end else if (state == ST_SAMP && sampleValid) begin
          if (lastSample) begin
            acc[ch*`OSC_ACC_W +: `OSC_ACC_W] <= {`OSC_ACC_W{1'b0}};
            // results only change as busy drops, so reads in flight
            // keep seeing the previous set
            resultData[ch*`OSC_DATA_W +: `OSC_DATA_W] <=
              mean[`OSC_DATA_W-1:0];
          end else begin
            acc[ch*`OSC_ACC_W +: `OSC_ACC_W] <= sum;
          end
        end
      end
    end
  endgenerate

endmodule

// File: dv/osc_props.sv
// checker for the conversion control block
// bound to its top module, sees only its ports
`timescale 1ns/1ps
module osc_props (
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // host pins
  input wire [2:0]  averaging_ratio_select,
  input wire        convert_start_first_half,
  input wire        convert_start_second_half,
  // converter core
  input wire        sampleRequest,
  input wire        sampleValid,
  input wire [63:0] sampleData,
  // status and results
  input wire        busy,
  input wire [2:0]  averaging_ratio,
  input wire [63:0] resultData
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_load; $fell(busy) |-> $past(sampleValid); endproperty
  a_load: assert property (p_load) else $error("busy fell early");
  property p_hold; !$fell(busy) |-> $stable(resultData); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_ratio; !$fell(busy) |-> $stable(averaging_ratio); endproperty
  a_ratio: assert property (p_ratio) else $error("ratio moved");
  property p_req; sampleRequest |-> busy ##1 !sampleRequest; endproperty
  a_req: assert property (p_req) else $error("bad request");
  property p_first; $rose(busy) |-> ##12 sampleRequest; endproperty
  a_first: assert property (p_first) else $error("first request");
  property p_gap;
    sampleValid |-> (##1 !busy) or (##13 sampleRequest);
  endproperty
  a_gap: assert property (p_gap) else $error("sample gap");
  property p_start;
    $rose(busy) |-> $past(convert_start_first_half, 4)
      && $past(convert_start_second_half, 4);
  endproperty
  a_start: assert property (p_start) else $error("start timing");
  property p_span; $rose(busy) |=> busy[*8]; endproperty
  a_span: assert property (p_span) else $error("busy short");
endmodule
bind osc_conversion_control osc_props osc_props_i (.clk_sys, .rst,
  .averaging_ratio_select, .convert_start_first_half,
  .convert_start_second_half, .sampleRequest, .sampleValid, .sampleData,
  .busy, .averaging_ratio, .resultData);

// File: dv/osc_core_model.sv
// converter core model: one sample set per request, wait of 0..3 cycles
// data off the valid cycle toggles so stale values are never trusted
`timescale 1ns/1ps
module osc_core_model (
  input wire        clk_sys,
  input wire        rst,
  input wire        sampleRequest,
  output reg        sampleValid,
  output reg [63:0] sampleData
);
  reg [15:0] n;
  reg [1:0]  w;
  reg        pend;
  always @(posedge clk_sys) begin
    sampleValid <= 1'b0;
    sampleData <= ~sampleData;
    if (rst) begin
      n <= 16'h0000;
      pend <= 1'b0;
      sampleData <= 64'h0000_0000_0000_0000;
    end else if (sampleRequest) begin
      pend <= 1'b1;
      w <= n[1:0];
    end else if (pend && w != 2'h0) begin
      w <= w - 2'h1;
    end else if (pend) begin
      pend <= 1'b0;
      sampleValid <= 1'b1;
      sampleData <= {16'(n * 4), 16'(n * 3), 16'(n * 2), n};
      n <= n + 16'h0001;
    end
  end
endmodule

// File: dv/osc_conversion_control_bench.sv
// bench: ratio sweep through all codes, reads during busy, averaging
// assumes the core model counts samples from zero after reset
`timescale 1ns/1ps
module osc_conversion_control_bench;
  reg clk_sys = 0, rst = 1, start = 0;
  reg [2:0] ratioSel = 3'h0, usedCode = 3'h0;
  wire sampleRequest, sampleValid, busy;
  wire [2:0] averaging_ratio;
  wire [63:0] sampleData, resultData;
  reg [63:0] prev = 64'h0000_0000_0000_0000;
  integer errTotal = 0, totalChecks = 0, n = 0;
  always #2 clk_sys = ~clk_sys;
  osc_conversion_control osc_conversion_control_i (.clk_sys, .rst,
    .averaging_ratio_select(ratioSel), .convert_start_first_half(start),
    .convert_start_second_half(start), .sampleRequest, .sampleValid,
    .sampleData, .busy, .averaging_ratio, .resultData);
  osc_core_model osc_core_model_i (.clk_sys, .rst, .sampleRequest,
    .sampleValid, .sampleData);
  task chk(input string nm, input [63:0] e, input [63:0] s);
    totalChecks++;
    if (s !== e) begin
      errTotal++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task completeRun;
    if (errTotal == 0 && totalChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task convert(input [2:0] c);
    integer i, k, m, v, t;
    reg [63:0] ex;
    begin
      m = (usedCode == 3'h7) ? 1 : 1 << usedCode;
      for (k = 0; k < 4; k++) begin
        t = 0;
        for (i = 0; i < m; i++) t += (n + i) * (k + 1);
        ex[16*k +: 16] = t / m;
      end
      @(posedge clk_sys);
      start <= 1'b1;
      ratioSel <= c;
      repeat (6) @(posedge clk_sys);
      #1 chk("busy", 1, busy);
      chk("held", prev, resultData);
      v = 0;
      t = 0;
      while (busy === 1'b1 && t < 4000) begin
        @(posedge clk_sys) #1 v += sampleValid;
        t++;
      end
      chk("count", m, v);
      chk("result", ex, resultData);
      chk("ratio", c, averaging_ratio);
      n += m;
      prev = ex;
      usedCode = c;
      @(posedge clk_sys) start <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask
  // each code set at one fall is used by the next conversion
  task sweep;
    integer c;
    for (c = 0; c < 8; c++) convert(c[2:0]);
    convert(3'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    sweep;
    completeRun;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errTotal++;
    completeRun;
  end
endmodule
